// ---- logic/dpt_timer.sv ----
// Summary of operation
// - two identical channels, one output pin each
// - duty settable zero to full, 1/250 steps
// - counter counts prescaled ticks while run set
// - counter counts 0 to f9 then wraps
// - output active on 0 to 1, unless duty zero
// - counter zero at reset, standby, run cleared
// - duty value maps linearly onto duty cycle
// - count equal to duty drives output inactive
// - running duty writes load at period wrap
// - stopped duty writes take effect at once
// - duty read returns the value in effect
// - duty register ff at reset and standby
// - control register 38 at reset and standby
// - control bit 7 gates counter and output
// - polarity bit 0 drives active state high
// - polarity bit 1 inverts the output level
// - clock select picks phi/2 through phi/4096
// - duty fa to ff holds output active
// - count tick on falling prescaler tap edge
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dpt_cfg.svh"

module dpt_timer (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic standby, // standby mode, same clock domain
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [17:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic pulse_out_ch0, // first channel pin level
  output logic pulse_out_ch1, // second channel pin level
  output logic pulse_en_ch0, // first channel pin drive enable
  output logic pulse_en_ch1 // second channel pin drive enable
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [15:0] CTRL_IDX [2] = '{`DPT_IDX_CTRL0,
                                         `DPT_IDX_CTRL1};
  localparam logic [15:0] DUTY_IDX [2] = '{`DPT_IDX_DUTY0,
                                         `DPT_IDX_DUTY1};
  localparam logic [15:0] COUNT_IDX [2] = '{`DPT_IDX_COUNT0,
                                          `DPT_IDX_COUNT1};
  localparam logic [7:0] CTRL_RST = `DPT_CTRL_RST;
  localparam dpt_pkg::dpt_ctrl_t CTRL_RST_S = '{
    run: CTRL_RST[`DPT_CTRL_RUN_BIT],
    polarity_select: CTRL_RST[`DPT_CTRL_POL_BIT],
    clock_select: CTRL_RST[`DPT_CTRL_CKS_MSB:0]};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [`DPT_PRESCALE_W-1:0] prescale;
  logic [15:0] idx;
  logic bus_req;
  logic bus_wr;
  logic [7:0] wdata;
  logic [7:0] rd_byte;
  logic rd_ctrl_q;
  dpt_pkg::dpt_ctrl_t ctrl [2];
  dpt_pkg::dpt_wr_t wr [2];
  logic [7:0] count [2];
  logic [7:0] duty_active [2];
  logic [7:0] duty_pending [2];
  logic [7:0] load_val [2];
  logic tap_now [2];
  logic tap_prev [2];
  logic tick [2];
  logic wrap [2];
  logic active [2];
  logic pin_level [2];

  // pick the prescaler bit whose period matches the clock select
  function automatic logic tap_sel(
    input logic [`DPT_PRESCALE_W-1:0] p,
    input logic [2:0] cks
  );
    logic [3:0] pos;
    pos = `DPT_TAP_DIV2;
    unique case (cks)
      3'h0: pos = `DPT_TAP_DIV2;
      3'h1: pos = `DPT_TAP_DIV8;
      3'h2: pos = `DPT_TAP_DIV32;
      3'h3: pos = `DPT_TAP_DIV128;
      3'h4: pos = `DPT_TAP_DIV256;
      3'h5: pos = `DPT_TAP_DIV1024;
      3'h6: pos = `DPT_TAP_DIV2048;
      3'h7: pos = `DPT_TAP_DIV4096;
    endcase
    return p[pos];
  endfunction : tap_sel

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // free running divider shared by both channels; standby clears it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= '0;
    end else if (standby) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + `DPT_PRESCALE_W'(1);
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  // one wait state: ack follows the request by one edge
  assign idx = wb_adr_i[17:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wdata = wb_dat_i[7:0];

  // ack pulses for one cycle, then drops even if the master holds on
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read mux; unmapped indices read as zero and still get an ack
  always_comb begin
    rd_byte = 8'h00;
    for (int c = 0; c < 2; c++) begin
      if (idx == CTRL_IDX[c]) begin
        rd_byte = {ctrl[c].run, ctrl[c].polarity_select,
                   `DPT_CTRL_RSV_READ, ctrl[c].clock_select};
      end
      if (idx == DUTY_IDX[c]) begin
        rd_byte = duty_active[c];
      end
      if (idx == COUNT_IDX[c]) begin
        rd_byte = count[c];
      end
    end
  end

  // read data is captured with the ack and then held
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
      rd_ctrl_q <= 1'b0;
    end else if (bus_req & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
      rd_ctrl_q <= ~wb_we_i & ((idx == CTRL_IDX[0]) |
                               (idx == CTRL_IDX[1]));
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch

    // write decode, taken at the ack edge only
    always_comb begin
      wr[c].ctrl = bus_wr & (idx == CTRL_IDX[c]);
      wr[c].duty = bus_wr & (idx == DUTY_IDX[c]);
      wr[c].count = bus_wr & (idx == COUNT_IDX[c]);
    end

    // count tick on the falling edge of the chosen tap; switching
    // the select from a high tap to a low one also yields a tick
    always_comb begin
      tap_now[c] = tap_sel(prescale, ctrl[c].clock_select);
      tick[c] = ctrl[c].run & tap_prev[c] & ~tap_now[c];
      wrap[c] = tick[c] & (count[c] == `DPT_COUNT_LAST);
      load_val[c] = wr[c].duty ? wdata : duty_pending[c];
    end

    // previous tap level for the edge detector
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        tap_prev[c] <= 1'b0;
      end else begin
        tap_prev[c] <= tap_now[c];
      end
    end

    // control register; reserved bits are simply not stored
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrl[c] <= CTRL_RST_S;
      end else if (standby) begin
        ctrl[c] <= CTRL_RST_S;
      end else if (wr[c].ctrl) begin
        ctrl[c] <= dpt_pkg::dpt_ctrl_t'({wdata[`DPT_CTRL_RUN_BIT],
                   wdata[`DPT_CTRL_POL_BIT],
                   wdata[`DPT_CTRL_CKS_MSB:0]});
      end
    end

    // period counter: clear beats a write, a write beats a tick
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        count[c] <= `DPT_COUNT_RST;
      end else if (standby | ~ctrl[c].run) begin
        count[c] <= `DPT_COUNT_RST;
      end else if (wr[c].count) begin
        count[c] <= wdata;
      end else if (wrap[c]) begin
        count[c] <= `DPT_COUNT_RST;
      end else if (tick[c]) begin
        count[c] <= count[c] + 8'h01;
      end
    end

    // duty buffer; a write in the wrap cycle lands at that wrap
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        duty_active[c] <= `DPT_DUTY_RST;
        duty_pending[c] <= `DPT_DUTY_RST;
      end else if (standby) begin
        duty_active[c] <= `DPT_DUTY_RST;
        duty_pending[c] <= `DPT_DUTY_RST;
      end else begin
        if (wr[c].duty) begin
          duty_pending[c] <= wdata;
        end
        if ((wr[c].duty & ~ctrl[c].run) | wrap[c]) begin
          duty_active[c] <= load_val[c];
        end
      end
    end

    // active state: high from count 1 until the count leaves the
    // duty value, so duty n gives n of 250 counts active
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        active[c] <= 1'b0;
      end else if (standby | ~ctrl[c].run) begin
        active[c] <= 1'b0;
      end else if (tick[c] & (count[c] == duty_active[c])) begin
        active[c] <= 1'b0;
      end else if (wrap[c] & (load_val[c] == `DPT_DUTY_ZERO)) begin
        active[c] <= 1'b0;
      end else if (tick[c] & (count[c] == `DPT_COUNT_RST) &
                   (duty_active[c] != `DPT_DUTY_ZERO)) begin
        active[c] <= 1'b1;
      end
    end

    // pin level registered; a stopped channel shows inactive level
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        pin_level[c] <= 1'b0;
      end else begin
        pin_level[c] <= ctrl[c].polarity_select ^
                        (ctrl[c].run & active[c]);
      end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_count_wrap;
      wrap[c] && !wr[c].count && !standby |=>
        count[c] == `DPT_COUNT_RST;
    endproperty
    a_count_wrap: assert property (p_count_wrap)
      else $error("counter did not wrap after f9");

    property p_count_step;
      tick[c] && !wrap[c] && !wr[c].count && !standby |=>
        count[c] == $past(count[c]) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
      else $error("counter missed a tick");

    property p_count_held;
      !ctrl[c].run |=> count[c] == `DPT_COUNT_RST;
    endproperty
    a_count_held: assert property (p_count_held)
      else $error("counter not held at zero while stopped");

    // a stopped channel never holds its output active
    property p_stopped_pin;
      !ctrl[c].run && !standby |=> !active[c];
    endproperty
    a_stopped_pin: assert property (p_stopped_pin)
      else $error("output active while channel stopped");

    property p_duty_zero;
      duty_active[c] == `DPT_DUTY_ZERO |-> !active[c];
    endproperty
    a_duty_zero: assert property (p_duty_zero)
      else $error("output active with zero duty");

    // a control write at the set edge changes run or polarity under
    // the pin, so the pin is judged against the control it was built from
    property p_set_on_one;
      tick[c] && count[c] == `DPT_COUNT_RST && !standby &&
        !wr[c].ctrl && duty_active[c] != `DPT_DUTY_ZERO |=> active[c] ##1
        pin_level[c] == !$past(ctrl[c].polarity_select);
    endproperty
    a_set_on_one: assert property (p_set_on_one)
      else $error("output not active after count 0 to 1");

    property p_clear_on_match;
      tick[c] && count[c] == duty_active[c] |=> !active[c];
    endproperty
    a_clear_on_match: assert property (p_clear_on_match)
      else $error("output still active after duty match");

    property p_full_duty;
      active[c] && duty_active[c] >= `DPT_DUTY_FULL &&
        ctrl[c].run && !wrap[c] && !standby |=> active[c];
    endproperty
    a_full_duty: assert property (p_full_duty)
      else $error("full duty output dropped");

    property p_polarity;
      1'b1 |=> pin_level[c] ==
        ($past(ctrl[c].polarity_select) ^
         ($past(ctrl[c].run) & $past(active[c])));
    endproperty
    a_polarity: assert property (p_polarity)
      else $error("pin level disagrees with polarity");

    property p_duty_buffered;
      ctrl[c].run && wr[c].duty && !wrap[c] && !standby |=>
        duty_active[c] == $past(duty_active[c]);
    endproperty
    a_duty_buffered: assert property (p_duty_buffered)
      else $error("running duty write took effect early");

    property p_duty_direct;
      !ctrl[c].run && wr[c].duty && !standby |=>
        duty_active[c] == $past(wdata);
    endproperty
    a_duty_direct: assert property (p_duty_direct)
      else $error("stopped duty write not applied");
  end

  // reserved control bits read back as ones
  property p_ctrl_rsv;
    wb_ack_o && rd_ctrl_q |-> wb_dat_o[5:3] == `DPT_CTRL_RSV_READ;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("reserved control bits not read as one");

  // ack is a single cycle pulse; a held request is acked again every other cycle
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus acknowledge held longer than one cycle");

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pulse_out_ch0 = pin_level[0];
  assign pulse_out_ch1 = pin_level[1];
  assign pulse_en_ch0 = ctrl[0].run;
  assign pulse_en_ch1 = ctrl[1].run;

endmodule : dpt_timer

`default_nettype wire

// ---- inc/dpt_cfg.svh ----
`ifndef DPT_CFG_SVH
`define DPT_CFG_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define DPT_IDX_CTRL0 16'hffa0
`define DPT_IDX_DUTY0 16'hffa1
`define DPT_IDX_COUNT0 16'hffa2
`define DPT_IDX_CTRL1 16'hffa4
`define DPT_IDX_DUTY1 16'hffa5
`define DPT_IDX_COUNT1 16'hffa6

// ****************************************************************
// reset values and field layout
// ****************************************************************
`define DPT_CTRL_RST 8'h38
`define DPT_DUTY_RST 8'hff
`define DPT_COUNT_RST 8'h00
`define DPT_CTRL_RUN_BIT 7
`define DPT_CTRL_POL_BIT 6
`define DPT_CTRL_CKS_MSB 2
`define DPT_CTRL_RSV_READ 3'h7

// ****************************************************************
// period and duty figures
// ****************************************************************
`define DPT_COUNT_LAST 8'hf9
`define DPT_COUNT_ONE 8'h01
`define DPT_DUTY_ZERO 8'h00
`define DPT_DUTY_FULL 8'hfa

// ****************************************************************
// prescaler taps: bit whose period is phi/2 .. phi/4096
// ****************************************************************
`define DPT_PRESCALE_W 12
`define DPT_TAP_DIV2 4'd0
`define DPT_TAP_DIV8 4'd2
`define DPT_TAP_DIV32 4'd4
`define DPT_TAP_DIV128 4'd6
`define DPT_TAP_DIV256 4'd7
`define DPT_TAP_DIV1024 4'd9
`define DPT_TAP_DIV2048 4'd10
`define DPT_TAP_DIV4096 4'd11

`endif

// ---- inc/dpt_pkg.sv ----
// ****************************************************************
// shared types of the dual channel modulation timer
// ****************************************************************
package dpt_pkg;

  // channel control as held in flops; bits 5..3 are not stored
  typedef struct packed {
    logic run;
    logic polarity_select;
    logic [2:0] clock_select;
  } dpt_ctrl_t;

  // one decoded bus write, per target register
  typedef struct packed {
    logic ctrl;
    logic duty;
    logic count;
  } dpt_wr_t;

endpackage : dpt_pkg

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dpt_cfg.svh"

module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic standby = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  wire [1:0] pout;
  wire [1:0] pen;
  int bad_count = 0;
  int checks_done = 0;

  // ****************************************************************
  // clock and design
  // ****************************************************************
  always #5 sys_clk = ~sys_clk;

  dpt_timer dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .standby(standby),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .pulse_out_ch0(pout[0]),
    .pulse_out_ch1(pout[1]),
    .pulse_en_ch0(pen[0]),
    .pulse_en_ch1(pen[1])
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  // one classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx,
                    input logic [7:0] d, input logic [3:0] s,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat[7:0];
    check("bus ack edges", 16'd2, n[15:0]);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, 4'h1, q);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [7:0] e,
                     input string name);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, 4'hf, q);
    check(name, {8'h0, e}, {8'h0, q});
  endtask : rdc

  // counts high pin cycles over a span; settled values at negedge
  task automatic measure(input int ch, input int span,
                         input logic [15:0] e, input string name);
    int hi;
    hi = 0;
    repeat (span) begin
      @(negedge sys_clk);
      if (pout[ch] === 1'b1) hi++;
    end
    check(name, e, hi[15:0]);
  endtask : measure

  // duty loaded while stopped so it applies at once, then started
  task automatic run_duty(input int ch, input logic [7:0] c,
                          input logic [7:0] d);
    logic [15:0] b;
    b = (ch == 1) ? `DPT_IDX_CTRL1 : `DPT_IDX_CTRL0;
    wr(b, 8'h00);
    wr(b + 16'h1, d);
    wr(b, c);
  endtask : run_duty

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [7:0] q;
    rdc(`DPT_IDX_CTRL0, 8'h38, "ctrl0 reset");
    rdc(`DPT_IDX_DUTY0, 8'hff, "duty0 reset");
    rdc(`DPT_IDX_COUNT0, 8'h00, "count0 reset");
    rdc(`DPT_IDX_CTRL1, 8'h38, "ctrl1 reset");
    rdc(`DPT_IDX_DUTY1, 8'hff, "duty1 reset");
    rdc(`DPT_IDX_COUNT1, 8'h00, "count1 reset");
    rdc(16'hffa3, 8'h00, "unmapped read");
    wr(`DPT_IDX_CTRL0, 8'h47);
    rdc(`DPT_IDX_CTRL0, 8'h7f, "reserved bits");
    wr(`DPT_IDX_CTRL0, 8'h00);
    rdc(`DPT_IDX_CTRL0, 8'h38, "reserved bits");
    wb(1'b1, `DPT_IDX_DUTY0, 8'h55, 4'h2, q);
    rdc(`DPT_IDX_DUTY0, 8'hff, "lane 0 off write");
    $display("test regs done");
  endtask : t_regs

  task automatic t_duty;
    logic [7:0] dv [5] = '{8'h00, 8'h7d, 8'hfa, 8'hff, 8'h02};
    logic [15:0] hv [5] = '{16'd0, 16'd250, 16'd500, 16'd500, 16'd4};
    for (int i = 0; i < 5; i++) begin
      run_duty(0, 8'h80, dv[i]);
      rdc(`DPT_IDX_DUTY0, dv[i], "duty stopped write");
      repeat (600) @(posedge sys_clk);
      measure(0, 500, hv[i], "ch0 active cycles");
      check("ch0 enable", 16'h1, {15'h0, pen[0]});
    end
    $display("test duty done");
  endtask : t_duty

  task automatic t_polarity;
    run_duty(0, 8'hc0, 8'h02);
    repeat (600) @(posedge sys_clk);
    measure(0, 500, 16'd496, "inverted active");
    wr(`DPT_IDX_CTRL0, 8'h40);
    repeat (2) @(posedge sys_clk);
    check("stopped inverted", 16'h1, {15'h0, pout[0]});
    $display("test polarity done");
  endtask : t_polarity

  task automatic t_clksel;
    for (int c = 0; c < 8; c++) begin
      wr(`DPT_IDX_CTRL0, 8'h80 | c[7:0]);
      rdc(`DPT_IDX_CTRL0, 8'hb8 | c[7:0], "clock select");
    end
    run_duty(0, 8'h81, 8'h7d);
    repeat (2100) @(posedge sys_clk);
    measure(0, 2000, 16'd1000, "divide by 8");
    run_duty(0, 8'h82, 8'h7d);
    repeat (8100) @(posedge sys_clk);
    measure(0, 8000, 16'd4000, "divide by 32");
    $display("test clksel done");
  endtask : t_clksel

  task automatic t_buffer;
    run_duty(0, 8'h80, 8'h02);
    repeat (100) @(posedge sys_clk);
    wr(`DPT_IDX_DUTY0, 8'h7d);
    rdc(`DPT_IDX_DUTY0, 8'h02, "pending duty");
    repeat (600) @(posedge sys_clk);
    rdc(`DPT_IDX_DUTY0, 8'h7d, "loaded duty");
    measure(0, 500, 16'd250, "loaded active");
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_stop;
    logic [7:0] a;
    logic [7:0] b;
    wb(1'b0, `DPT_IDX_COUNT0, 8'h00, 4'hf, a);
    wb(1'b0, `DPT_IDX_COUNT0, 8'h00, 4'hf, b);
    check("count moving", 16'h1, {15'h0, a !== b});
    wr(`DPT_IDX_CTRL0, 8'h00);
    rdc(`DPT_IDX_COUNT0, 8'h00, "count cleared");
    repeat (4) @(posedge sys_clk);
    rdc(`DPT_IDX_COUNT0, 8'h00, "count held");
    check("ch0 enable off", 16'h0, {15'h0, pen[0]});
    check("ch0 pin off", 16'h0, {15'h0, pout[0]});
    $display("test stop done");
  endtask : t_stop

  task automatic t_ch1;
    run_duty(1, 8'h80, 8'h7d);
    repeat (600) @(posedge sys_clk);
    measure(1, 500, 16'd250, "ch1 active");
    check("ch0 pin idle", 16'h0, {15'h0, pout[0]});
    check("ch1 enable", 16'h1, {15'h0, pen[1]});
    @(posedge sys_clk);
    standby <= 1'b1;
    repeat (3) @(posedge sys_clk);
    standby <= 1'b0;
    rdc(`DPT_IDX_CTRL1, 8'h38, "ctrl1 standby");
    rdc(`DPT_IDX_DUTY1, 8'hff, "duty1 standby");
    rdc(`DPT_IDX_COUNT1, 8'h00, "count1 standby");
    check("ch1 pin standby", 16'h0, {15'h0, pout[1]});
    $display("test ch1 done");
  endtask : t_ch1

  // ****************************************************************
  // verdict, watchdog and main sequence
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // the tests take about 30k cycles; this allows twice that
  initial begin
    #600000;
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_duty;
    t_polarity;
    t_clksel;
    t_buffer;
    t_stop;
    t_ch1;
    tally_and_finish;
  end
endmodule : tb

`default_nettype wire
